// ==== design/mcpwm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mcpwm_cfg.svh"

module mcpwm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [5:0]  pwm_out,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // State

    mcpwm_pkg::mcpwm_word_t   tc_reg, tc_next;
    mcpwm_pkg::mcpwm_word_t   pr_reg, pr_next;
    mcpwm_pkg::mcpwm_word_t   pc_reg, pc_next;
    mcpwm_pkg::mcpwm_word_t   mr_sh_reg  [7];
    mcpwm_pkg::mcpwm_word_t   mr_sh_next [7];
    mcpwm_pkg::mcpwm_word_t   mr_act_reg [7];
    mcpwm_pkg::mcpwm_word_t   mr_act_next[7];
    mcpwm_pkg::mcpwm_mvec_t   status_reg, status_next;
    mcpwm_pkg::mcpwm_mvec_t   mask_reg, mask_next;
    mcpwm_pkg::mcpwm_mvec_t   ler_reg, ler_next;
    mcpwm_pkg::mcpwm_action_t act_reg, act_next;
    mcpwm_pkg::mcpwm_outcfg_t ocfg_reg, ocfg_next;
    logic [3:0]               ctrl_reg, ctrl_next;
    logic [6:1]               out_reg, out_next;
    logic [31:0]              prdata_reg, prdata_next;
    logic                     pready_reg, pready_next;
    logic                     pslverr_reg, pslverr_next;
    logic                     irq_reg, irq_next;

    mcpwm_pkg::mcpwm_mvec_t   match, rst_bits, stop_bits, int_bits;
    logic                     run, tick, pwm_on, wr, rd_cap, wr_tc, hit;
    logic [3:0]               msel;

    // Match register index decode: {hit, index}
    function automatic logic [3:0] mr_sel(input logic [7:0] a);
        logic [7:0] d;
        d = a - `MCPWM_OFF_MATCH0;
        mr_sel = {(a >= `MCPWM_OFF_MATCH0) && (d[7:2] < 6'h07) && (a[1:0] == 2'h0), d[4:2]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Counter, matches and outputs

    always_comb begin
        msel   = mr_sel(paddr);
        pwm_on = ctrl_reg[`MCPWM_CTRL_PWM];
        run    = ctrl_reg[`MCPWM_CTRL_RUN] & ~ctrl_reg[`MCPWM_CTRL_CLR];
        tick   = run && (pc_reg == pr_reg);
        for (int i = 0; i < `MCPWM_NMATCH; i++) begin
            match[i]     = tick && (tc_reg == mr_act_reg[i]);
            int_bits[i]  = act_reg[3*i + `MCPWM_ACT_INT];
            rst_bits[i]  = act_reg[3*i + `MCPWM_ACT_RST];
            stop_bits[i] = act_reg[3*i + `MCPWM_ACT_STOP];
        end
        // Modulation mode closes the cycle at the period match, except when COUNT is written in that cycle
        rst_bits[0] = rst_bits[0] | pwm_on;
        wr     = psel & penable & pready_reg & pwrite;
        rd_cap = psel & penable & ~pready_reg;
        wr_tc  = wr && (paddr == `MCPWM_OFF_COUNT);
        hit    = msel[3] || (paddr == `MCPWM_OFF_STATUS) || (paddr == `MCPWM_OFF_MASK)
                 || (paddr == `MCPWM_OFF_CTRL) || (paddr == `MCPWM_OFF_COUNT)
                 || (paddr == `MCPWM_OFF_PRESC) || (paddr == `MCPWM_OFF_PCOUNT)
                 || (paddr == `MCPWM_OFF_ACTION) || (paddr == `MCPWM_OFF_OUTCFG)
                 || (paddr == `MCPWM_OFF_RELEASE) || (paddr == `MCPWM_OFF_OUTSTAT);

        // Prescaler
        if (ctrl_reg[`MCPWM_CTRL_CLR]) begin
            pc_next = `MCPWM_RST_WORD;
        end else if (!run) begin
            pc_next = pc_reg;
        end else if (tick) begin
            pc_next = `MCPWM_RST_WORD;
        end else begin
            pc_next = pc_reg + 32'h0000_0001;
        end

        // Main counter
        if (ctrl_reg[`MCPWM_CTRL_CLR]) begin
            tc_next = `MCPWM_RST_WORD;
        end else if (wr_tc) begin
            tc_next = pwdata;
        end else if (tick && |(match & rst_bits)) begin
            tc_next = `MCPWM_RST_WORD;
        end else if (tick) begin
            tc_next = tc_reg + 32'h0000_0001;
        end else begin
            tc_next = tc_reg;
        end

        // Software registers
        pr_next   = (wr && paddr == `MCPWM_OFF_PRESC) ? pwdata : pr_reg;
        mask_next = (wr && paddr == `MCPWM_OFF_MASK) ? pwdata[6:0] : mask_reg;
        act_next  = (wr && paddr == `MCPWM_OFF_ACTION) ? pwdata[20:0] : act_reg;
        ocfg_next = (wr && paddr == `MCPWM_OFF_OUTCFG) ? pwdata[14:0] : ocfg_reg;
        ctrl_next = (wr && paddr == `MCPWM_OFF_CTRL) ? pwdata[3:0] : ctrl_reg;
        if (|(match & stop_bits)) begin
            ctrl_next[`MCPWM_CTRL_RUN] = 1'b0;
        end

        // Sticky match flags, a new event wins over a write-one clear
        status_next = status_reg;
        if (wr && paddr == `MCPWM_OFF_STATUS) begin
            status_next = status_reg & ~pwdata[6:0];
        end
        status_next = status_next | (match & int_bits);

        // Shadow and active match values
        ler_next = ler_reg;
        for (int i = 0; i < `MCPWM_NMATCH; i++) begin
            mr_sh_next[i]  = mr_sh_reg[i];
            mr_act_next[i] = mr_act_reg[i];
            if (pwm_on && match[0] && ler_reg[i]) begin
                mr_act_next[i] = mr_sh_reg[i];
                ler_next[i]    = 1'b0;
            end
            if (wr && msel[3] && msel[2:0] == i[2:0]) begin
                mr_sh_next[i] = pwdata;
                if (!pwm_on) begin
                    mr_act_next[i] = pwdata;
                end
            end
        end
        if (wr && paddr == `MCPWM_OFF_RELEASE) begin
            ler_next = ler_next | pwdata[6:0];
        end

        // Output channels; a clearing edge wins over a setting one
        for (int n = 1; n < `MCPWM_NMATCH; n++) begin
            logic set_ev;
            set_ev = (n >= 2 && ocfg_reg[n]) ? match[n-1] : match[0];
            if (!pwm_on || !ocfg_reg[`MCPWM_OUTCFG_EN + n - 1]) begin
                out_next[n] = 1'b0;
            end else if (match[n]) begin
                out_next[n] = 1'b0;
            end else if (set_ev) begin
                out_next[n] = 1'b1;
            end else begin
                out_next[n] = out_reg[n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer and interrupt

    always_comb begin
        prdata_next  = prdata_reg;
        pready_next  = rd_cap;
        pslverr_next = rd_cap & ~hit;
        if (rd_cap) begin
            prdata_next = 32'h0000_0000;
            if (msel[3]) begin
                prdata_next = mr_sh_reg[msel[2:0]];
            end else begin
                unique case (paddr)
                    `MCPWM_OFF_STATUS:  prdata_next = {25'h0, status_reg};
                    `MCPWM_OFF_MASK:    prdata_next = {25'h0, mask_reg};
                    `MCPWM_OFF_CTRL:    prdata_next = {28'h0, ctrl_reg};
                    `MCPWM_OFF_COUNT:   prdata_next = tc_reg;
                    `MCPWM_OFF_PRESC:   prdata_next = pr_reg;
                    `MCPWM_OFF_PCOUNT:  prdata_next = pc_reg;
                    `MCPWM_OFF_ACTION:  prdata_next = {11'h0, act_reg};
                    `MCPWM_OFF_OUTCFG:  prdata_next = {17'h0, ocfg_reg};
                    `MCPWM_OFF_RELEASE: prdata_next = {25'h0, ler_reg};
                    `MCPWM_OFF_OUTSTAT: prdata_next = {25'h0, out_reg, 1'b0};
                    default:            prdata_next = 32'h0000_0000;
                endcase
            end
        end
        irq_next = |(status_next & mask_next);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_reg      <= `MCPWM_RST_WORD;
            pr_reg      <= `MCPWM_RST_WORD;
            pc_reg      <= `MCPWM_RST_WORD;
            status_reg  <= `MCPWM_RST_MVEC;
            mask_reg    <= `MCPWM_RST_MVEC;
            ler_reg     <= `MCPWM_RST_MVEC;
            act_reg     <= 21'h000000;
            ocfg_reg    <= 15'h0000;
            ctrl_reg    <= 4'h0;
            out_reg     <= 6'h00;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
            for (int i = 0; i < `MCPWM_NMATCH; i++) begin
                mr_sh_reg[i]  <= `MCPWM_RST_WORD;
                mr_act_reg[i] <= `MCPWM_RST_WORD;
            end
        end else begin
            tc_reg      <= tc_next;
            pr_reg      <= pr_next;
            pc_reg      <= pc_next;
            status_reg  <= status_next;
            mask_reg    <= mask_next;
            ler_reg     <= ler_next;
            act_reg     <= act_next;
            ocfg_reg    <= ocfg_next;
            ctrl_reg    <= ctrl_next;
            out_reg     <= out_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg     <= irq_next;
            for (int i = 0; i < `MCPWM_NMATCH; i++) begin
                mr_sh_reg[i]  <= mr_sh_next[i];
                mr_act_reg[i] <= mr_act_next[i];
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign pwm_out = out_reg;
    assign irq     = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    counter_reset_a: assert property (
        match[0] && pwm_on && !ctrl_reg[`MCPWM_CTRL_CLR] && !wr_tc |=> tc_reg == 32'h0000_0000)
        else $error("counter not cleared at period match");

    prescale_step_a: assert property (
        run && !tick |=> pc_reg == $past(pc_reg) + 32'h0000_0001)
        else $error("prescaler did not step");

    count_advance_a: assert property (
        tick && !(|(match & rst_bits)) && !wr_tc && !ctrl_reg[`MCPWM_CTRL_CLR]
        |=> tc_reg == $past(tc_reg) + 32'h0000_0001 && pc_reg == 32'h0000_0000)
        else $error("counter did not advance on prescale tick");

    single_rise_a: assert property (
        pwm_on && ocfg_reg[`MCPWM_OUTCFG_EN] && match[0] && !match[1] ##1 pwm_on
        |-> pwm_out[0])
        else $error("single edge output did not rise at period match");

    single_fall_a: assert property (
        pwm_on && match[1] |=> !pwm_out[0])
        else $error("single edge output did not fall at its match");

    double_edge_a: assert property (
        pwm_on && ocfg_reg[2] && ocfg_reg[`MCPWM_OUTCFG_EN + 1] && match[1] && !match[2]
        |=> pwm_out[1])
        else $error("double edge output did not rise on its set match");

    stop_on_match_a: assert property (
        |(match & stop_bits) |=> !run ##1 $stable(tc_reg) || $past(wr_tc)
            || $past(ctrl_reg[`MCPWM_CTRL_CLR]))
        else $error("counter kept running after stop match");

    match_flag_a: assert property (
        match[3] && int_bits[3] |=> status_reg[3] ##1 irq_reg == |(status_reg & mask_reg)
            || $past(wr))
        else $error("match flag or interrupt wrong");

    release_apply_a: assert property (
        pwm_on && match[0] && ler_reg[2] |=> mr_act_reg[2] == $past(mr_sh_reg[2]) && !ler_reg[2]
            || $past(wr))
        else $error("released value not applied at period match");

    hold_active_a: assert property (
        pwm_on && !match[0] ##1 pwm_on |-> $stable(mr_act_reg[1]))
        else $error("active match value changed outside cycle boundary");

endmodule
`default_nettype wire

// ==== design/mcpwm_cfg.svh ====
`ifndef MCPWM_CFG_SVH
`define MCPWM_CFG_SVH
// Register byte offsets
`define MCPWM_OFF_STATUS  8'h00
`define MCPWM_OFF_MASK    8'h04
`define MCPWM_OFF_CTRL    8'h08
`define MCPWM_OFF_COUNT   8'h0c
`define MCPWM_OFF_PRESC   8'h10
`define MCPWM_OFF_PCOUNT  8'h14
`define MCPWM_OFF_ACTION  8'h18
`define MCPWM_OFF_MATCH0  8'h1c
`define MCPWM_OFF_OUTCFG  8'h38
`define MCPWM_OFF_RELEASE 8'h3c
`define MCPWM_OFF_OUTSTAT 8'h40
// Control field positions
`define MCPWM_CTRL_RUN    0
`define MCPWM_CTRL_CLR    1
`define MCPWM_CTRL_PWM    3
// Per-match action field, three bits per match register
`define MCPWM_ACT_INT     0
`define MCPWM_ACT_RST     1
`define MCPWM_ACT_STOP    2
// Output enable of channel n sits at OUTCFG bit EN+n-1
`define MCPWM_OUTCFG_EN   9
`define MCPWM_NMATCH      7
// Reset values
`define MCPWM_RST_WORD    32'h0000_0000
`define MCPWM_RST_MVEC    7'h00
`endif

// ==== design/mcpwm_pkg.sv ====
package mcpwm_pkg;
    typedef logic [31:0] mcpwm_word_t;
    typedef logic [6:0]  mcpwm_mvec_t;
    typedef logic [20:0] mcpwm_action_t;
    typedef logic [14:0] mcpwm_outcfg_t;
endpackage

// ==== sim/mcpwm_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Load on the six pins: counts high cycles and rising edges per pin
module mcpwm_load_model (
    input  wire logic             clk,
    input  wire logic             clr,
    input  wire logic [5:0]       pins,
    output logic      [5:0][15:0] hi_cnt,
    output logic      [5:0][15:0] rise_cnt
);
    logic [5:0] prev;

    always_ff @(posedge clk) begin
        prev <= pins;
        for (int k = 0; k < 6; k++) begin
            if (clr) begin
                hi_cnt[k]   <= 16'h0;
                rise_cnt[k] <= 16'h0;
            end else begin
                hi_cnt[k]   <= hi_cnt[k] + 16'(pins[k]);
                rise_cnt[k] <= rise_cnt[k] + 16'(pins[k] & ~prev[k]);
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mcpwm_cfg.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    localparam int M = 9;
    localparam int P = 1;
    localparam int T = (M + 1) * (P + 1);
    localparam int K = 4;
    logic             pclk    = 1'b0;
    logic             presetn = 1'b0;
    logic             psel    = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite  = 1'b0;
    logic [7:0]       paddr   = 8'h00;
    logic [31:0]      pwdata  = 32'h0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [5:0]       pwm_out;
    logic             irq;
    logic             clr     = 1'b0;
    logic [5:0][15:0] hi_cnt;
    logic [5:0][15:0] rise_cnt;
    int               errors  = 0;
    int               checked = 0;
    int               cyc     = 0;

    mcpwm_top u_mcpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));
    mcpwm_load_model u_mcpwm_load_model (.clk(pclk), .clr(clr), .pins(pwm_out),
        .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

    always #25 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end

    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic cfg(input int mv[7], input logic [31:0] oc);
        wr(`MCPWM_OFF_CTRL, 32'h2);
        wr(`MCPWM_OFF_PRESC, 32'(P));
        for (int i = 0; i < 7; i++) begin
            wr(`MCPWM_OFF_MATCH0 + 8'(4 * i), 32'(mv[i]));
        end
        wr(`MCPWM_OFF_OUTCFG, oc);
        wr(`MCPWM_OFF_CTRL, 32'h9);
        repeat (3 * T) @(posedge pclk);
    endtask

    // Counts over K whole periods, so the phase of the window does not matter
    task automatic measure(input int rise[6], input int fall[6]);
        int h;
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (K * T) @(posedge pclk);
        #1;
        for (int k = 0; k < 6; k++) begin
            h = (fall[k] - rise[k] + M + 1) % (M + 1);
            `CHK("high_time", 16'(h * (P + 1) * K), hi_cnt[k])
            `CHK("pulses", (h == 0) ? 16'h0 : 16'(K), rise_cnt[k])
        end
    endtask

    ////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        `CHK("pins_idle", 6'h00, pwm_out)
        rd(`MCPWM_OFF_CTRL, r);
        `CHK("ctrl_rst", 32'h0, r)
        apb(1'b0, 8'h80, 32'h0, r, e);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, r)
    endtask

    task automatic t_timer();
        logic [31:0] r;
        logic [31:0] c;
        wr(`MCPWM_OFF_MATCH0 + 8'h04, 32'h5);
        wr(`MCPWM_OFF_ACTION, 32'h28);
        wr(`MCPWM_OFF_MASK, 32'h2);
        wr(`MCPWM_OFF_CTRL, 32'h1);
        repeat (20) @(posedge pclk);
        rd(`MCPWM_OFF_STATUS, r);
        `CHK("match_flag", 1'b1, r[1])
        rd(`MCPWM_OFF_CTRL, r);
        `CHK("run_cleared", 1'b0, r[0])
        rd(`MCPWM_OFF_COUNT, c);
        repeat (10) @(posedge pclk);
        rd(`MCPWM_OFF_COUNT, r);
        `CHK("count_stopped", c, r)
        `CHK("timer_pins", 6'h00, pwm_out)
        `CHK("irq_set", 1'b1, irq)
        wr(`MCPWM_OFF_MASK, 32'h0);
        @(posedge pclk);
        #1;
        `CHK("irq_masked", 1'b0, irq)
        wr(`MCPWM_OFF_MASK, 32'h2);
        wr(`MCPWM_OFF_STATUS, 32'h2);
        @(posedge pclk);
        #1;
        `CHK("irq_cleared", 1'b0, irq)
        wr(`MCPWM_OFF_ACTION, 32'h0);
    endtask

    // Match 3 resets the counter and flags, without stopping it
    task automatic t_wrap();
        logic [31:0] r;
        wr(`MCPWM_OFF_CTRL, 32'h2);
        wr(`MCPWM_OFF_MATCH0 + 8'h0c, 32'h3);
        wr(`MCPWM_OFF_ACTION, 32'h600);
        wr(`MCPWM_OFF_CTRL, 32'h1);
        repeat (20) @(posedge pclk);
        rd(`MCPWM_OFF_COUNT, r);
        `CHK("count_wrapped", 1'b1, r < 32'h4)
        rd(`MCPWM_OFF_CTRL, r);
        `CHK("run_kept", 1'b1, r[0])
        rd(`MCPWM_OFF_STATUS, r);
        `CHK("reset_flag", 1'b1, r[3])
        `CHK("irq_masked_flag", 1'b0, irq)
        wr(`MCPWM_OFF_CTRL, 32'h0);
        wr(`MCPWM_OFF_COUNT, 32'h1234);
        rd(`MCPWM_OFF_COUNT, r);
        `CHK("count_load", 32'h1234, r)
        wr(`MCPWM_OFF_ACTION, 32'h0);
        wr(`MCPWM_OFF_STATUS, 32'h7f);
    endtask

    task automatic t_single();
        cfg('{9, 0, 2, 4, 6, 8, 9}, 32'h7e00);
        measure('{9, 9, 9, 9, 9, 9}, '{0, 2, 4, 6, 8, 9});
    endtask

    task automatic t_release();
        logic [31:0] r;
        wr(`MCPWM_OFF_MATCH0 + 8'h04, 32'h4);
        wr(`MCPWM_OFF_MATCH0 + 8'h08, 32'h3);
        measure('{9, 9, 9, 9, 9, 9}, '{0, 2, 4, 6, 8, 9});
        wr(`MCPWM_OFF_RELEASE, 32'h6);
        repeat (2 * T) @(posedge pclk);
        rd(`MCPWM_OFF_RELEASE, r);
        `CHK("release_done", 32'h0, r)
        measure('{9, 9, 9, 9, 9, 9}, '{4, 3, 4, 6, 8, 9});
    endtask

    task automatic t_double();
        cfg('{9, 6, 2, 3, 8, 1, 9}, 32'h7e54);
        measure('{9, 6, 9, 3, 9, 1}, '{6, 2, 3, 8, 1, 9});
    endtask

    task automatic stop_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_timer();
        t_wrap();
        t_single();
        t_release();
        t_double();
        stop_test();
    end
endmodule
`default_nettype wire
